/* rtl/ipsc_top.sv */
// Purpose: interrupt priority, external lines, timer-0, port change and context capture
// Assumes: inputs synchronous to I_MCLK, one-cycle event pulses
// Notes:   all state frozen while I_CE is low
`timescale 1ns/1ps
module ipsc_top
  import ipsc_pkg::*;
(
  input  wire logic              I_MCLK,
  input  wire logic              I_RESETN,
  input  wire logic              I_CE,
  input  wire logic [ADDR_W-1:0] I_ADDR,
  input  wire logic [DATA_W-1:0] I_WDATA,
  input  wire logic              I_WR,
  input  wire logic              I_RD,
  input  wire logic [EXT_N-1:0]  I_EXT,
  input  wire logic              I_T0_TICK,
  input  wire logic [3:0]        I_PORTB_HI,
  input  wire logic              I_PORTB_ACCESS,
  input  wire logic [PER_N-1:0]  I_PER_EVT,
  input  wire logic              I_SLEEP,
  input  wire logic              I_RESET_INSTR,
  input  wire logic              I_WDT_EXPIRE,
  input  wire logic              I_WDT_CLEAR,
  input  wire logic              I_IRQ_ACK,
  input  wire ipsc_ctx_t         I_CTX,
  output logic [DATA_W-1:0]      O_RDATA,
  output logic                   O_IRQ_HIGH,
  output logic                   O_IRQ_LOW,
  output logic                   O_WAKE,
  output logic                   O_WAKE_VECTOR,
  output logic                   O_STACK_PUSH,
  output logic [PC_W-1:0]        O_STACK_PC,
  output ipsc_ctx_t              O_SHADOW
);

  // ==========================================================================
  // state
  logic [PER_N-1:0] prio2_q;
  logic             priority_levels_enable_q, ri_q, to_q, pd_q, por_q, bor_q;
  logic             gie_q, peripheral_irq_gate_q, t0en_q, pcen_q, t0f_q, pcf_q;
  logic [EXT_N-1:0] ext_en_q, ext_f_q, ext_prev_q, edge_q, snap_en_q;
  logic [2:1]       ext_prio_q;
  logic             t0prio_q, pcprio_q, m16_q, run_q;
  logic [7:0]       tlow_q, thigh_q;
  logic [PER_N-1:0] pflag_q, pen_q;
  logic [3:0]       pb_latch_q;
  logic             sleep_prev_q, woke_q;
  logic [DATA_W-1:0] rd_d;

  logic wr_p2, wr_rc, wr_c1, wr_c2, wr_c3, wr_tc, wr_tl, wr_th, wr_pf, wr_pe;
  assign wr_p2 = I_CE & I_WR & (I_ADDR == OFS_PRIO2);
  assign wr_rc = I_CE & I_WR & (I_ADDR == OFS_RESET_CONTROL_STATUS);
  assign wr_c1 = I_CE & I_WR & (I_ADDR == OFS_CTRL1);
  assign wr_c2 = I_CE & I_WR & (I_ADDR == OFS_CTRL2);
  assign wr_c3 = I_CE & I_WR & (I_ADDR == OFS_CTRL3);
  assign wr_tc = I_CE & I_WR & (I_ADDR == OFS_TCFG);
  assign wr_tl = I_CE & I_WR & (I_ADDR == OFS_TLOW);
  assign wr_th = I_CE & I_WR & (I_ADDR == OFS_THIGH);
  assign wr_pf = I_CE & I_WR & (I_ADDR == OFS_PFLAG2);
  assign wr_pe = I_CE & I_WR & (I_ADDR == OFS_PEN2);
  // ==========================================================================
  // priority, reset-control and enables
  always_ff @(posedge I_MCLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      prio2_q <= PRIO2_RST;
      priority_levels_enable_q  <= 1'b0;
    end else if (I_CE) begin
      if (wr_p2) prio2_q <= I_WDATA[PER_N-1:0];
      if (wr_rc) priority_levels_enable_q <= I_WDATA[RC_PRIORITY_LEVELS_ENABLE];
    end
  end

  always_ff @(posedge I_MCLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      ri_q  <= 1'b1;
      to_q  <= 1'b1;
      pd_q  <= 1'b1;
      por_q <= 1'b0;
      bor_q <= 1'b0;
    end else if (I_CE) begin
      if (I_RESET_INSTR) ri_q <= 1'b0;
      else if (wr_rc) ri_q <= I_WDATA[RC_RI];
      if (I_WDT_EXPIRE) to_q <= 1'b0;
      else if (I_WDT_CLEAR) to_q <= 1'b1;
      if (I_SLEEP & ~sleep_prev_q) pd_q <= 1'b0;
      else if (I_WDT_CLEAR) pd_q <= 1'b1;
      if (wr_rc) begin
        por_q <= I_WDATA[RC_POR];
        bor_q <= I_WDATA[RC_BOR];
      end
    end
  end

  always_ff @(posedge I_MCLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      gie_q      <= 1'b0;
      peripheral_irq_gate_q     <= 1'b0;
      t0en_q     <= 1'b0;
      pcen_q     <= 1'b0;
      ext_en_q   <= '0;
      edge_q     <= '1;
      ext_prio_q <= 2'h3;
      t0prio_q   <= 1'b1;
      pcprio_q   <= 1'b1;
      m16_q      <= 1'b0;
      run_q      <= 1'b0;
      pen_q      <= '0;
    end else if (I_CE) begin
      if (wr_c1) begin
        gie_q       <= I_WDATA[C1_GIE];
        peripheral_irq_gate_q      <= I_WDATA[C1_PERIPHERAL_IRQ_GATE];
        t0en_q      <= I_WDATA[C1_T0E];
        ext_en_q[0] <= I_WDATA[C1_X0E];
        pcen_q      <= I_WDATA[C1_PCE];
      end
      if (wr_c2) begin
        edge_q   <= I_WDATA[C2_EDG0 -: EXT_N];
        t0prio_q <= I_WDATA[C2_T0P];
        pcprio_q <= I_WDATA[C2_PCP];
      end
      if (wr_c3) begin
        ext_prio_q  <= {I_WDATA[C3_X2P], I_WDATA[C3_X1P]};
        ext_en_q[1] <= I_WDATA[C3_X1E];
        ext_en_q[2] <= I_WDATA[C3_X2E];
      end
      if (wr_tc) begin
        m16_q <= I_WDATA[TC_M16];
        run_q <= I_WDATA[TC_RUN];
      end
      if (wr_pe) pen_q <= I_WDATA[PER_N-1:0];
    end
  end
  // ==========================================================================
  // external lines
  logic [EXT_N-1:0] edge_hit, ext_f_we, ext_f_wv;
  assign ext_f_we = {wr_c3, wr_c3, wr_c1};
  assign ext_f_wv = {I_WDATA[C3_X2F], I_WDATA[C3_X1F], I_WDATA[C1_X0F]};

  for (genvar g = 0; g < EXT_N; g++) begin : g_ext
    assign edge_hit[g] = edge_q[g] ? (I_EXT[g] & ~ext_prev_q[g]) : (~I_EXT[g] & ext_prev_q[g]);
    always_ff @(posedge I_MCLK or negedge I_RESETN) begin
      if (!I_RESETN) begin
        ext_prev_q[g] <= 1'b0;
        ext_f_q[g]    <= 1'b0;
      end else if (I_CE) begin
        ext_prev_q[g] <= I_EXT[g];
        if (ext_f_we[g]) ext_f_q[g] <= ext_f_wv[g] | edge_hit[g];
        else ext_f_q[g] <= ext_f_q[g] | edge_hit[g];
      end
    end
  end
  // ==========================================================================
  // timer zero
  logic t0_inc, t0_roll;
  assign t0_inc  = run_q & I_T0_TICK;
  assign t0_roll = t0_inc & (tlow_q == TMAX8) & (~m16_q | (thigh_q == TMAX8));

  always_ff @(posedge I_MCLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      tlow_q  <= 8'h00;
      thigh_q <= 8'h00;
      t0f_q   <= 1'b0;
    end else if (I_CE) begin
      if (wr_tl) tlow_q <= I_WDATA;
      else if (t0_inc) tlow_q <= tlow_q + 8'h01;
      if (wr_th) thigh_q <= I_WDATA;
      else if (t0_inc & m16_q & (tlow_q == TMAX8)) thigh_q <= thigh_q + 8'h01;
      if (wr_c1) t0f_q <= I_WDATA[C1_T0F] | t0_roll;
      else t0f_q <= t0f_q | t0_roll;
    end
  end
  // ==========================================================================
  // port change and peripheral flags
  logic pb_mismatch;
  assign pb_mismatch = |(I_PORTB_HI ^ pb_latch_q);

  always_ff @(posedge I_MCLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      pb_latch_q <= 4'h0;
      pcf_q      <= 1'b0;
      pflag_q    <= '0;
    end else if (I_CE) begin
      if (I_PORTB_ACCESS) pb_latch_q <= I_PORTB_HI;
      if (wr_c1) pcf_q <= I_WDATA[C1_PCF] | pb_mismatch;
      else pcf_q <= pcf_q | pb_mismatch;
      if (wr_pf) pflag_q <= I_WDATA[PER_N-1:0] | I_PER_EVT;
      else pflag_q <= pflag_q | I_PER_EVT;
    end
  end
  // ==========================================================================
  // request generation
  logic [4:0] core_pend, core_prio;
  logic [PER_N-1:0] per_pend;
  logic hi_d, lo_d;
  assign core_pend = {pcf_q & pcen_q, t0f_q & t0en_q, ext_f_q & ext_en_q};
  assign core_prio = {pcprio_q, t0prio_q, ext_prio_q, 1'b1};
  assign per_pend  = pflag_q & pen_q;

  always_comb begin
    if (priority_levels_enable_q) begin
      hi_d = gie_q & (|(core_pend & core_prio) | |(per_pend & prio2_q));
      lo_d = gie_q & peripheral_irq_gate_q & (|(core_pend & ~core_prio) | |(per_pend & ~prio2_q));
    end else begin
      hi_d = gie_q & (|core_pend | (peripheral_irq_gate_q & |per_pend));
      lo_d = 1'b0;
    end
  end

  always_ff @(posedge I_MCLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      O_IRQ_HIGH <= 1'b0;
      O_IRQ_LOW  <= 1'b0;
    end else if (I_CE) begin
      O_IRQ_HIGH <= hi_d;
      O_IRQ_LOW  <= lo_d;
    end
  end
  // ==========================================================================
  // sleep wake-up
  logic wake_hit;
  assign wake_hit = I_SLEEP & sleep_prev_q & ~woke_q & |(ext_f_q & snap_en_q);

  always_ff @(posedge I_MCLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      sleep_prev_q  <= 1'b0;
      snap_en_q     <= '0;
      woke_q        <= 1'b0;
      O_WAKE        <= 1'b0;
      O_WAKE_VECTOR <= 1'b0;
    end else if (I_CE) begin
      sleep_prev_q <= I_SLEEP;
      if (I_SLEEP & ~sleep_prev_q) begin
        snap_en_q <= ext_en_q;
        woke_q    <= 1'b0;
      end else if (wake_hit) begin
        woke_q <= 1'b1;
      end
      O_WAKE <= wake_hit;
      if (wake_hit) O_WAKE_VECTOR <= gie_q;
    end
  end
  // ==========================================================================
  // context capture
  always_ff @(posedge I_MCLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      O_STACK_PUSH <= 1'b0;
      O_STACK_PC   <= '0;
      O_SHADOW     <= '0;
    end else if (I_CE) begin
      O_STACK_PUSH <= I_IRQ_ACK;
      if (I_IRQ_ACK) begin
        O_STACK_PC <= I_CTX.pc;
        O_SHADOW   <= I_CTX;
      end
    end
  end
  // ==========================================================================
  // register read
  always_comb begin
    rd_d = 8'h00;
    unique case (I_ADDR)
      OFS_PRIO2:  rd_d = {3'h0, prio2_q};
      OFS_RESET_CONTROL_STATUS:   rd_d = {priority_levels_enable_q, 2'h0, ri_q, to_q, pd_q, por_q, bor_q};
      OFS_CTRL1:  rd_d = {gie_q, peripheral_irq_gate_q, t0en_q, ext_en_q[0], pcen_q, t0f_q, ext_f_q[0], pcf_q};
      OFS_CTRL2:  rd_d = {1'b0, edge_q, 1'b0, t0prio_q, 1'b0, pcprio_q};
      OFS_CTRL3:  rd_d = {ext_prio_q[2], ext_prio_q[1], 1'b0, ext_en_q[2], ext_en_q[1], 1'b0, ext_f_q[2], ext_f_q[1]};
      OFS_TCFG:   rd_d = {6'h00, run_q, m16_q};
      OFS_TLOW:   rd_d = tlow_q;
      OFS_THIGH:  rd_d = thigh_q;
      OFS_PFLAG2: rd_d = {3'h0, pflag_q};
      OFS_PEN2:   rd_d = {3'h0, pen_q};
      default:    rd_d = 8'h00;
    endcase
  end

  always_ff @(posedge I_MCLK or negedge I_RESETN) begin
    if (!I_RESETN) O_RDATA <= 8'h00;
    else if (I_CE) O_RDATA <= I_RD ? rd_d : 8'h00;
  end
  // ==========================================================================
  // checks
  default clocking cb @(posedge I_MCLK); endclocking
  default disable iff (!I_RESETN);
  sequence s_sleeping_pending;
    I_CE && I_SLEEP && sleep_prev_q && !woke_q && |(ext_f_q & snap_en_q);
  endsequence
  AST_PRIO2_UPPER_ZERO: assert property (I_CE && I_RD && I_ADDR == OFS_PRIO2 |=> O_RDATA[7:5] == 3'h0)
    else $error("priority register upper bits not zero");
  AST_RESET_CONTROL_STATUS_GAP_ZERO: assert property (I_CE && I_RD && I_ADDR == OFS_RESET_CONTROL_STATUS |=> O_RDATA[6:5] == 2'h0)
    else $error("reset control bits 6..5 not zero");
  AST_EXT0_RISE_FLAG: assert property (I_CE && edge_q[0] && !ext_prev_q[0] && I_EXT[0] |=> ext_f_q[0])
    else $error("rising edge on line 0 did not set flag");
  AST_EXT1_FALL_FLAG: assert property (I_CE && !edge_q[1] && ext_prev_q[1] && !I_EXT[1] |=> ext_f_q[1])
    else $error("falling edge on line 1 did not set flag");
  AST_NO_GIE_NO_IRQ: assert property (I_CE && !gie_q |=> !O_IRQ_HIGH && !O_IRQ_LOW)
    else $error("interrupt raised with global enable clear");
  AST_LINE0_HIGH: assert property (I_CE && priority_levels_enable_q && gie_q && ext_f_q[0] && ext_en_q[0] |=> O_IRQ_HIGH)
    else $error("line 0 not routed to high priority");
  AST_NO_LOW_SINGLE: assert property (I_CE && !priority_levels_enable_q |=> !O_IRQ_LOW)
    else $error("low request in single level mode");
  AST_PER_GATE: assert property (I_CE && !priority_levels_enable_q && gie_q && !peripheral_irq_gate_q && core_pend == 5'h00 |=> !O_IRQ_HIGH)
    else $error("peripheral request passed closed gate");
  AST_T0_ROLL8: assert property (I_CE && run_q && I_T0_TICK && !m16_q && !wr_tl && tlow_q == TMAX8
    |=> t0f_q && tlow_q == 8'h00)
    else $error("timer zero 8-bit rollover missed");
  AST_PORT_CHANGE: assert property (I_CE && pb_mismatch |=> pcf_q)
    else $error("port change did not set flag");
  AST_CTX_PUSH: assert property (I_CE && I_IRQ_ACK |=> O_STACK_PUSH && O_STACK_PC == $past(I_CTX.pc)
    && O_SHADOW == $past(I_CTX))
    else $error("context not captured on entry");
  AST_WAKE_VECTOR: assert property (s_sleeping_pending |=> O_WAKE && O_WAKE_VECTOR == $past(gie_q))
    else $error("wake or vector decision wrong");

endmodule : ipsc_top

/* rtl/ipsc_pkg.sv */
// Purpose: shared constants and types of the interrupt priority and source block
// Assumes: 8-bit register port, one system clock
// Notes:   offsets are register indices on the plain register port
package ipsc_pkg;

  // ==========================================================================
  // widths
  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned PC_W   = 21;
  localparam int unsigned EXT_N  = 3;
  localparam int unsigned PER_N  = 5;

  // ==========================================================================
  // register offsets
  localparam logic [ADDR_W-1:0] OFS_PRIO2  = 4'h0;
  localparam logic [ADDR_W-1:0] OFS_RESET_CONTROL_STATUS   = 4'h1;
  localparam logic [ADDR_W-1:0] OFS_CTRL1  = 4'h2;
  localparam logic [ADDR_W-1:0] OFS_CTRL2  = 4'h3;
  localparam logic [ADDR_W-1:0] OFS_CTRL3  = 4'h4;
  localparam logic [ADDR_W-1:0] OFS_TCFG   = 4'h5;
  localparam logic [ADDR_W-1:0] OFS_TLOW   = 4'h6;
  localparam logic [ADDR_W-1:0] OFS_THIGH  = 4'h7;
  localparam logic [ADDR_W-1:0] OFS_PFLAG2 = 4'h8;
  localparam logic [ADDR_W-1:0] OFS_PEN2   = 4'h9;

  // ==========================================================================
  // field positions
  localparam int unsigned RC_PRIORITY_LEVELS_ENABLE = 7;
  localparam int unsigned RC_RI   = 4;
  localparam int unsigned RC_TO   = 3;
  localparam int unsigned RC_PD   = 2;
  localparam int unsigned RC_POR  = 1;
  localparam int unsigned RC_BOR  = 0;
  localparam int unsigned C1_GIE  = 7;
  localparam int unsigned C1_PERIPHERAL_IRQ_GATE = 6;
  localparam int unsigned C1_T0E  = 5;
  localparam int unsigned C1_X0E  = 4;
  localparam int unsigned C1_PCE  = 3;
  localparam int unsigned C1_T0F  = 2;
  localparam int unsigned C1_X0F  = 1;
  localparam int unsigned C1_PCF  = 0;
  localparam int unsigned C2_EDG0 = 6;
  localparam int unsigned C2_T0P  = 2;
  localparam int unsigned C2_PCP  = 0;
  localparam int unsigned C3_X2P  = 7;
  localparam int unsigned C3_X1P  = 6;
  localparam int unsigned C3_X2E  = 4;
  localparam int unsigned C3_X1E  = 3;
  localparam int unsigned C3_X2F  = 1;
  localparam int unsigned C3_X1F  = 0;
  localparam int unsigned TC_M16  = 0;
  localparam int unsigned TC_RUN  = 1;

  // ==========================================================================
  // values after reset and the timer count limit
  localparam logic [PER_N-1:0] PRIO2_RST = 5'h1F;
  localparam logic [7:0]       TMAX8     = 8'hFF;

  // ==========================================================================
  // context handed over on interrupt entry
  typedef struct packed {
    logic [PC_W-1:0] pc;
    logic [7:0]      working_accumulator;
    logic [7:0]      status;
    logic [7:0]      bank_select;
  } ipsc_ctx_t;

endpackage : ipsc_pkg

/* testbench/ipsc_core_model.sv */
// Purpose: core sequencer model that takes interrupt entries
// Assumes: request levels straight from ipsc_top, prompt or slow answer
// Notes:   context pattern changes every cycle so a stale capture shows
`timescale 1ns/1ps
module ipsc_core_model
  import ipsc_pkg::*;
(
  input  wire logic i_clk,
  input  wire logic i_rst_n,
  input  wire logic i_slow,
  input  wire logic i_req,
  output logic      o_ack,
  output ipsc_ctx_t o_ctx,
  output ipsc_ctx_t o_taken
);
  logic [2:0] wait_q;
  logic       busy_q;

  // ==========================================================================
  // entry sequencing
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_ack  <= 1'b0;
      busy_q <= 1'b0;
      wait_q <= 3'h0;
    end else begin
      o_ack <= 1'b0;
      if (!busy_q && i_req) begin
        wait_q <= wait_q + 3'h1;
        if (wait_q == (i_slow ? 3'h5 : 3'h0)) begin
          o_ack  <= 1'b1;
          busy_q <= 1'b1;
          wait_q <= 3'h0;
        end
      end else if (busy_q && !i_req) begin
        busy_q <= 1'b0;
      end else if (!i_req) begin
        wait_q <= 3'h0;
      end
    end
  end

  // ==========================================================================
  // running context and the copy the handler keeps
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_ctx   <= '0;
      o_taken <= '0;
    end else begin
      o_ctx <= {o_ctx[$bits(ipsc_ctx_t)-2:0], ~o_ctx[$bits(ipsc_ctx_t)-1]};
      if (o_ack) begin
        o_taken <= o_ctx;
      end
    end
  end
endmodule : ipsc_core_model

/* testbench/test_interrupt_priority_and_sources.sv */
// Purpose: self-checking bench of ipsc_top
// Assumes: core model answers every request
// Notes:   read data checked against a queue of expected bytes
`timescale 1ns/1ps
module test_interrupt_priority_and_sources
  import ipsc_pkg::*;
;
  logic              clk, rst_n, wr, rd, tick, pacc, slp, slow, ack, rd_pend;
  logic              irq_h, irq_l, wake, wvec, push, exp_vec;
  logic              ce, rinst, wdx, wdc;
  logic [ADDR_W-1:0] addr;
  logic [ADDR_W-1:0] offs [6];
  logic [DATA_W-1:0] wdata, rdata;
  logic [EXT_N-1:0]  ext;
  logic [3:0]        pb;
  logic [PER_N-1:0]  pevt;
  logic [PC_W-1:0]   spc;
  logic [15:0]       lfsr;
  logic [55:0]       rows [14];
  ipsc_ctx_t         ctx, shadow, taken;
  logic [7:0]        expq [$];
  int                mismatches, n_checks, cyc, n_wake, n_push, n_ack;

  ipsc_top dut_u (
    .I_MCLK(clk), .I_RESETN(rst_n), .I_CE(ce), .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr), .I_RD(rd),
    .I_EXT(ext), .I_T0_TICK(tick), .I_PORTB_HI(pb), .I_PORTB_ACCESS(pacc), .I_PER_EVT(pevt), .I_SLEEP(slp),
    .I_RESET_INSTR(rinst), .I_WDT_EXPIRE(wdx), .I_WDT_CLEAR(wdc), .I_IRQ_ACK(ack), .I_CTX(ctx),
    .O_RDATA(rdata), .O_IRQ_HIGH(irq_h), .O_IRQ_LOW(irq_l), .O_WAKE(wake), .O_WAKE_VECTOR(wvec),
    .O_STACK_PUSH(push), .O_STACK_PC(spc), .O_SHADOW(shadow));
  ipsc_core_model core_u (.i_clk(clk), .i_rst_n(rst_n), .i_slow(slow), .i_req(irq_h | irq_l),
    .o_ack(ack), .o_ctx(ctx), .o_taken(taken));

  // ==========================================================================
  // helpers
  function automatic logic [15:0] nxt(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction : nxt
  task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected %s: expected %0h seen %0h", what, exp, seen);
    end
  endtask : check
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : summarize
  task automatic cyc_n(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc_n
  task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clk);
    wr    <= 1'b1;
    addr  <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
    @(posedge clk);
    rd   <= 1'b1;
    addr <= a;
    expq.push_back(e);
    @(posedge clk);
    rd <= 1'b0;
  endtask : rd_reg
  task automatic clr(input logic [7:0] c1, input logic [7:0] c3);
    wr_reg(OFS_CTRL1, c1);
    wr_reg(OFS_CTRL3, c3);
    wr_reg(OFS_PFLAG2, 8'h00);
  endtask : clr
  task automatic tick_n(input int n);
    @(posedge clk) tick <= 1'b1;
    cyc_n(n);
    tick <= 1'b0;
  endtask : tick_n
  task automatic wait_wake(input int n);
    for (int i = 0; i < 20 && n_wake < n; i++) @(posedge clk);
    check("wake count", n_wake, n);
  endtask : wait_wake

  // ==========================================================================
  // clock and output monitors
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) begin
    if (rd_pend && expq.size() > 0) check("read data", rdata, expq.pop_front());
    rd_pend <= rd;
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      mismatches++;
      summarize();
    end
  end
  always @(negedge clk) begin
    if (ack) n_ack++;
    if (wake) begin
      n_wake++;
      check("wake vector", wvec, exp_vec);
    end
    if (push) begin
      n_push++;
      check("stack pc", spc, taken.pc);
      check("shadow", shadow, taken);
    end
  end

  // ==========================================================================
  // main sequence
  initial begin
    rows = '{56'h80C774C11F0000, 56'h80C774C91F0010, 56'h80C774891F0001, 56'h80477489_1F0000,
             56'h00C774891F0010, 56'h80D774011F0010, 56'h80E770011F0001, 56'h80E774011F0010,
             56'h80CF75011F0010, 56'h80CF74011F0001, 56'h80C77401000201, 56'h80C77401020210,
             56'h00877401000200, 56'h00C77401000210};
    offs = '{OFS_RESET_CONTROL_STATUS, OFS_CTRL1, OFS_CTRL2, OFS_CTRL3, OFS_PRIO2, OFS_PEN2};
    {rst_n, wr, rd, tick, pacc, slp, slow, rd_pend, exp_vec, rinst, wdx, wdc} = '0;
    ce = 1'b1;
    {addr, wdata, ext, pb, pevt} = '0;
    lfsr = 16'hB494;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    rd_reg(OFS_PRIO2, 8'h1F);
    rd_reg(OFS_RESET_CONTROL_STATUS, 8'h1C);
    rd_reg(4'hF, 8'h00);
    for (int i = 0; i < 4; i++) begin
      lfsr = nxt(lfsr);
      wr_reg(OFS_PRIO2, lfsr[7:0]);
      rd_reg(OFS_PRIO2, {3'h0, lfsr[4:0]});
    end
    // clock enable low: the write must be ignored
    ce <= 1'b0;
    wr_reg(OFS_PRIO2, 8'h00);
    ce <= 1'b1;
    rd_reg(OFS_PRIO2, {3'h0, lfsr[4:0]});
    wr_reg(OFS_RESET_CONTROL_STATUS, 8'hFF);
    rd_reg(OFS_RESET_CONTROL_STATUS, 8'h9F);
    @(posedge clk) {rinst, wdx} <= 2'h3;
    @(posedge clk) {rinst, wdx} <= 2'h0;
    rd_reg(OFS_RESET_CONTROL_STATUS, 8'h87);
    @(posedge clk) wdc <= 1'b1;
    @(posedge clk) wdc <= 1'b0;
    wr_reg(OFS_RESET_CONTROL_STATUS, 8'h00);
    rd_reg(OFS_RESET_CONTROL_STATUS, 8'h0C);
    @(posedge clk) pacc <= 1'b1;
    @(posedge clk) pacc <= 1'b0;
    // edge polarity per line, enables off
    for (int p = 0; p < 2; p++) begin
      wr_reg(OFS_CTRL2, p ? 8'h75 : 8'h05);
      @(posedge clk) ext <= p ? 3'h0 : 3'h7;
      for (int l = 0; l < 3; l++) begin
        clr(8'h00, 8'hC0);
        @(posedge clk) ext[l] <= p[0];
        cyc_n(2);
        rd_reg(OFS_CTRL1, l == 0 ? 8'h02 : 8'h00);
        rd_reg(OFS_CTRL3, 8'hC0 | 8'(l));
        clr(8'h00, 8'hC0);
        @(posedge clk) ext[l] <= ~p[0];
        cyc_n(2);
        rd_reg(OFS_CTRL1, 8'h00);
        rd_reg(OFS_CTRL3, 8'hC0);
      end
    end
    // sleep wake-up, global enable off then on
    for (int g = 0; g < 2; g++) begin
      @(posedge clk) ext <= 3'h0;
      clr(g ? 8'h80 : 8'h00, 8'hC8);
      exp_vec = g[0];
      @(posedge clk) slp <= 1'b1;
      cyc_n(3);
      @(posedge clk) ext[2] <= 1'b1;
      cyc_n(4);
      check("wake count", n_wake, g);
      @(posedge clk) ext[1] <= 1'b1;
      wait_wake(g + 1);
      @(posedge clk) slp <= 1'b0;
    end
    rd_reg(OFS_RESET_CONTROL_STATUS, 8'h08);
    @(posedge clk) ext <= 3'h0;
    clr(8'h00, 8'hC0);
    // timer-0 rollover in both widths
    wr_reg(OFS_TCFG, 8'h02);
    wr_reg(OFS_TLOW, 8'hFE);
    tick_n(1);
    rd_reg(OFS_CTRL1, 8'h00);
    tick_n(1);
    rd_reg(OFS_CTRL1, 8'h04);
    rd_reg(OFS_TLOW, 8'h00);
    clr(8'h00, 8'hC0);
    wr_reg(OFS_TCFG, 8'h03);
    wr_reg(OFS_THIGH, 8'hFE);
    wr_reg(OFS_TLOW, 8'hFF);
    tick_n(1);
    rd_reg(OFS_CTRL1, 8'h00);
    rd_reg(OFS_THIGH, 8'hFF);
    wr_reg(OFS_TLOW, 8'hFF);
    tick_n(1);
    rd_reg(OFS_CTRL1, 8'h04);
    rd_reg(OFS_THIGH, 8'h00);
    wr_reg(OFS_TCFG, 8'h00);
    // raise lines 0 and 1, port change and peripheral 1, then walk the enable and priority table
    @(posedge clk) begin
      ext  <= 3'h3;
      pevt <= 5'h02;
      pb   <= 4'h8;
    end
    @(posedge clk) pevt <= 5'h00;
    cyc_n(2);
    rd_reg(OFS_CTRL1, 8'h07);
    rd_reg(OFS_CTRL3, 8'hC1);
    rd_reg(OFS_PFLAG2, 8'h02);
    for (int r = 0; r < 14; r++) begin
      slow = r[0];
      for (int k = 0; k < 6; k++) wr_reg(offs[k], rows[r][55-8*k -: 8]);
      cyc_n(3);
      @(negedge clk);
      check("irq high", irq_h, rows[r][4]);
      check("irq low", irq_l, rows[r][0]);
    end
    wr_reg(OFS_CTRL1, 8'h00);
    cyc_n(12);
    check("push count", n_push, n_ack);
    check("entries seen", n_push > 0, 1'b1);
    summarize();
  end
endmodule : test_interrupt_priority_and_sources
